// ---- rtl/pwr_seq_pkg.sv ----
// Contract
// - seven states: off, power-down, hard reset, default, idle, transmit, receive
// - on when io supply and enable high
// - in hard reset: drivers off, inputs off, pulls on
// - after reset, unprogrammed: inputs and pulls on
// - no io supply, enable low: fully off
package pwr_seq_pkg;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_POWER_DOWN,
        ST_HARD_RESET,
        ST_DEFAULT,
        ST_IDLE,
        ST_TRANSMIT,
        ST_RECEIVE
    } pwr_state_e;

    localparam int          CLK_HZ          = 40_000_000;
    localparam int          SETTLE_MS       = 5;
    localparam int          SETTLE_CYCLES   = CLK_HZ / 1000 * SETTLE_MS;
    localparam int          PIN_COUNT       = 9;
    localparam logic [2:0]  STATE_RESET     = 3'h0;
endpackage

// ---- rtl/pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_s;

    sync_s state_q;
    sync_s state_d;

    always_comb begin
        state_d.meta   = async_in;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_out = state_q.stable;
endmodule // pin_sync
`default_nettype wire

// ---- rtl/power_state_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none
module power_state_sequencer #(
    parameter int PINS = pwr_seq_pkg::PIN_COUNT
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   io_supply,
    input  wire logic                   core_power_enable,
    input  wire logic                   active_low_reset_input_n,
    input  wire logic                   fw_configured,
    input  wire logic                   tx_active,
    input  wire logic                   rx_active,
    input  wire logic [PINS-1:0]        fw_out_en,
    input  wire logic [PINS-1:0]        fw_pull_en,
    output logic                        core_supply_on,
    output logic                        core_reset_n,
    output pwr_seq_pkg::pwr_state_e     power_state,
    output logic [PINS-1:0]             pad_out_en,
    output logic [PINS-1:0]             pad_in_en,
    output logic [PINS-1:0]             pad_pull_en
);
    import pwr_seq_pkg::*;

    typedef struct packed {
        pwr_state_e         state;
        logic               supply_on;
        logic               rst_n;
        logic [PINS-1:0]    oe;
        logic [PINS-1:0]    ie;
        logic [PINS-1:0]    pe;
    } seq_s;

    seq_s       state_q;
    seq_s       state_d;
    logic [2:0] pins_sync;
    logic       io_ok;
    logic       en_ok;
    logic       rst_rel;

    // pins come from the board, outside the clock domain
    pin_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({io_supply, core_power_enable, active_low_reset_input_n}),
        .sync_out (pins_sync)
    );

    assign io_ok   = pins_sync[2];
    assign en_ok   = pins_sync[1];
    assign rst_rel = pins_sync[0];

    always_comb begin
        state_d = state_q;
        // enable low overrides everything; reset assumed held with it
        if (!io_ok && !en_ok) begin
            state_d.state = ST_OFF;
        end else if (!en_ok || !io_ok) begin
            state_d.state = ST_POWER_DOWN;
        end else if (!rst_rel) begin
            state_d.state = ST_HARD_RESET;
        end else begin
            case (state_q.state)
                ST_HARD_RESET, ST_POWER_DOWN, ST_OFF: begin
                    state_d.state = ST_DEFAULT;
                end
                ST_DEFAULT: begin
                    if (fw_configured) begin
                        state_d.state = ST_IDLE;
                    end
                end
                ST_IDLE, ST_TRANSMIT, ST_RECEIVE: begin
                    // transmit wins: both active is not expected
                    if (!fw_configured) begin
                        state_d.state = ST_DEFAULT;
                    end else if (tx_active) begin
                        state_d.state = ST_TRANSMIT;
                    end else if (rx_active) begin
                        state_d.state = ST_RECEIVE;
                    end else begin
                        state_d.state = ST_IDLE;
                    end
                end
                default: begin
                    state_d.state = ST_OFF;
                end
            endcase
        end

        state_d.supply_on = 1'b0;
        state_d.rst_n     = 1'b0;
        state_d.oe        = '0;
        state_d.ie        = '0;
        state_d.pe        = '0;
        case (state_d.state)
            ST_HARD_RESET: begin
                state_d.supply_on = 1'b1;
                state_d.pe        = '1;
            end
            ST_DEFAULT: begin
                state_d.supply_on = 1'b1;
                state_d.rst_n     = 1'b1;
                state_d.ie        = '1;
                state_d.pe        = '1;
            end
            ST_IDLE, ST_TRANSMIT, ST_RECEIVE: begin
                state_d.supply_on = 1'b1;
                state_d.rst_n     = 1'b1;
                state_d.oe        = fw_out_en;
                state_d.ie        = ~fw_out_en;
                state_d.pe        = fw_pull_en;
            end
            default: begin
                state_d.supply_on = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '{state: ST_OFF, supply_on: 1'b0, rst_n: 1'b0,
                         oe: '0, ie: '0, pe: '0};
        end else begin
            state_q <= state_d;
        end
    end

    assign core_supply_on = state_q.supply_on;
    assign core_reset_n   = state_q.rst_n;
    assign power_state    = state_q.state;
    assign pad_out_en     = state_q.oe;
    assign pad_in_en      = state_q.ie;
    assign pad_pull_en    = state_q.pe;
endmodule // power_state_sequencer
`default_nettype wire

// ---- tb/host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module host_model #(
    parameter int SETTLE = 20
) (
    input  wire logic clk,
    input  wire logic io_want,
    input  wire logic on_want,
    output logic      io_supply,
    output logic      core_power_enable,
    output logic      active_low_reset_input_n
);
    // settle shortened: the device does not time it
    int cnt = 0;
    initial {io_supply, core_power_enable, active_low_reset_input_n} = 3'h0;
    always @(negedge clk) begin
        io_supply <= io_want | core_power_enable;
        core_power_enable <= on_want & io_want & io_supply;
        cnt <= core_power_enable ? cnt + 1 : 0;
        active_low_reset_input_n <= on_want & io_want
            & core_power_enable & (cnt >= SETTLE);
    end
endmodule // host_model
`default_nettype wire

// ---- tb/power_state_sequencer_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module power_state_sequencer_checker #(
    parameter int PINS = pwr_seq_pkg::PIN_COUNT
) (
    input wire logic                   clk,
    input wire logic                   reset_n,
    input wire logic                   core_power_enable,
    input wire logic                   active_low_reset_input_n,
    input wire logic                   tx_active,
    input wire logic                   rx_active,
    input wire logic                   core_supply_on,
    input wire logic                   core_reset_n,
    input wire pwr_seq_pkg::pwr_state_e power_state,
    input wire logic [PINS-1:0]        pad_out_en,
    input wire logic [PINS-1:0]        pad_in_en,
    input wire logic [PINS-1:0]        pad_pull_en
);
    import pwr_seq_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic up_st = power_state inside
        {ST_DEFAULT, ST_IDLE, ST_TRANSMIT, ST_RECEIVE};
    a_supply_state: assert property (
        core_supply_on == (up_st || power_state == ST_HARD_RESET))
        else $error("bad supply");
    a_reset_out: assert property (core_reset_n == up_st)
        else $error("bad core reset");
    a_hard_pads: assert property (power_state == ST_HARD_RESET |->
        !(|{pad_out_en, pad_in_en}) && &pad_pull_en) else $error("hard pads");
    a_default_pads: assert property (power_state == ST_DEFAULT |->
        !(|pad_out_en) && &pad_in_en && &pad_pull_en) else $error("def pads");
    a_off_pads: assert property (!core_supply_on |->
        !(|{pad_out_en, pad_in_en, pad_pull_en})) else $error("off pads");
    a_rx_cause: assert property (power_state == ST_RECEIVE |->
        $past(rx_active) && !$past(tx_active)) else $error("bad receive");
    a_tx_cause: assert property (power_state == ST_TRANSMIT |->
        $past(tx_active)) else $error("bad transmit");
    a_enable_fall: assert property ($fell(core_power_enable) |->
        ##[1:4] !core_supply_on) else $error("late power down");
    a_reset_fall: assert property ($fell(active_low_reset_input_n) |->
        ##[1:4] !core_reset_n) else $error("late hard reset");
    c_tx: cover property (power_state == ST_TRANSMIT);
    c_rx: cover property (power_state == ST_RECEIVE);
    c_down: cover property (power_state == ST_POWER_DOWN);
endmodule // power_state_sequencer_checker
bind power_state_sequencer power_state_sequencer_checker #(.PINS(PINS))
    power_state_sequencer_checker_i (.*);
`default_nettype wire

// ---- tb/power_state_sequencer_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module power_state_sequencer_tb;
    import pwr_seq_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, io_want = 1'b0, on_want = 1'b0;
    logic fw_configured = 1'b0, tx_active = 1'b0, rx_active = 1'b0;
    logic [8:0] fw_out_en = 9'h0a5, fw_pull_en = 9'h13c;
    logic io_supply, core_power_enable, active_low_reset_input_n;
    logic core_supply_on, core_reset_n;
    logic [8:0] pad_out_en, pad_in_en, pad_pull_en;
    pwr_state_e power_state;
    int miscompares = 0, checks_done = 0;
    always #12.5 clk = ~clk;
    host_model host_model_i (.*);
    power_state_sequencer power_state_sequencer_i (.*);
    task automatic chk_v(logic [8:0] got, logic [8:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_st(pwr_state_e got, pwr_state_e exp);
        chk_v(9'(got), 9'(exp));
    endtask
    task automatic wt(ref logic s, input logic v);
        repeat (80) if (s !== v) @(negedge clk);
    endtask
    task automatic power_up;
        {io_want, on_want} = 2'h3;
        wt(core_supply_on, 1'b1);
        chk_st(power_state, ST_HARD_RESET);
        chk_v(pad_pull_en & ~pad_in_en & ~pad_out_en, 9'h1ff);
        wt(core_reset_n, 1'b1);
        chk_st(power_state, ST_DEFAULT);
        chk_v(pad_in_en & pad_pull_en & ~pad_out_en, 9'h1ff);
    endtask
    task automatic modes;
        pwr_state_e exp[4] = '{ST_IDLE, ST_TRANSMIT, ST_RECEIVE, ST_TRANSMIT};
        fw_configured = 1'b1;
        for (int i = 0; i < 4; i++) begin
            {rx_active, tx_active} = 2'(i);
            @(negedge clk);
            chk_st(power_state, exp[i]);
            chk_v(pad_out_en, 9'h0a5);
            chk_v(pad_in_en, 9'h15a);
            chk_v(pad_pull_en, 9'h13c);
        end
        fw_configured = 1'b0;
        @(negedge clk);
        chk_st(power_state, ST_DEFAULT);
    endtask
    task automatic power_down;
        on_want = 1'b0;
        wt(core_supply_on, 1'b0);
        chk_st(power_state, ST_POWER_DOWN);
        io_want = 1'b0;
        repeat (6) @(negedge clk);
        chk_st(power_state, ST_OFF);
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        power_up;
        modes;
        power_down;
        test_done;
    end
    initial begin
        #(600 * 25);
        miscompares++;
        test_done;
    end
endmodule // power_state_sequencer_tb
`default_nettype wire
